// *** bench/tb.sv ***
/*
  Self-checking bench for the 8-bit waveform timer: registers over
  AXI4-Lite, tick pulses, port pin seen through a pulled-down load.
  Assumes the register map and encodings of tmw_pkg.
*/
module tb
  import tmw_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ------------------------------------------------------------
  // signals
  // ------------------------------------------------------------
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic timer_tick = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0] wstrb = 4'hF;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b1;
  logic arvalid = 1'b0;
  logic rready = 1'b1;
  logic awready, wready, bvalid, arready, rvalid, pin_out, pin_oe, pin_level;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [33:0] rd_q[$];
  logic [1:0] b_q[$];
  int fail_count = 0;
  int n_tests = 0;
  int cyc = 0;
  logic [15:0] lfsr = 16'hE105;
  logic [7:0] c, p;
  logic oc;

  always #4 aclk = ~aclk;

  tmw_timer dut_u (.aclk(aclk), .aresetn(aresetn), .timer_tick(timer_tick),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
    .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .pin_out(pin_out), .pin_oe(pin_oe));
  tmw_pin_load load_u (.pin_out(pin_out), .pin_oe(pin_oe), .pin_level(pin_level));

  // ------------------------------------------------------------
  // helpers and comparisons
  // ------------------------------------------------------------
  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  function automatic logic [7:0] ctl(input logic f, input logic [1:0] o, input logic [1:0] m);
    return {f, 1'b0, o, 2'b00, m};
  endfunction

  task automatic bad(input logic [33:0] e, input logic [33:0] g);
    fail_count++;
    $display("BAD t=%0t exp=%h got=%h", $time, e, g);
  endtask

  task automatic cmp_rd(input logic [33:0] e, input logic [33:0] g);
    n_tests++;
    if (g !== e) bad(e, g);
  endtask

  task automatic cmp_b(input logic [1:0] e, input logic [1:0] g);
    n_tests++;
    if (g !== e) bad(34'(e), 34'(g));
  endtask

  task automatic cmp_pin(input logic [1:0] e, input logic [1:0] g);
    n_tests++;
    if (g !== e) bad(34'(e), 34'(g));
  endtask

  // ------------------------------------------------------------
  // bus master and tick driver
  // ------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] r = RESP_OKAY);
    logic aw_ok = 1'b0;
    logic w_ok = 1'b0;
    b_q.push_back(r);
    awaddr <= a;
    wdata <= {24'h00_0000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (!aw_ok && awready === 1'b1) begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w_ok && wready === 1'b1) begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (bvalid !== 1'b1);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] v, input logic [1:0] r = RESP_OKAY);
    rd_q.push_back({r, 24'h00_0000, v});
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
  endtask

  task automatic tk(input int n);
    repeat (n) begin
      timer_tick <= 1'b1;
      @(posedge aclk);
    end
    timer_tick <= 1'b0;
    @(posedge aclk);
  endtask

  // pin register lags its source by one cycle
  task automatic chk_pin(input logic e_oe, input logic e_lvl);
    repeat (2) @(posedge aclk);
    cmp_pin({e_oe, e_lvl}, {pin_oe, pin_level});
  endtask

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // ------------------------------------------------------------
  // monitor and timeout
  // ------------------------------------------------------------
  always @(posedge aclk) begin
    if (rvalid === 1'b1 && rready) cmp_rd(rd_q.pop_front(), {rresp, rdata});
    if (bvalid === 1'b1 && bready) cmp_b(b_q.pop_front(), bresp);
  end

  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      tally_and_finish();
    end
  end

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    for (int i = 0; i < 5; i++) rd(8'(4 * i), 8'h00);
    rd(8'h14, 8'h00, RESP_SLVERR);
    wr(8'h14, 8'hFF, RESP_SLVERR);
    chk_pin(1'b0, 1'b0);
    wr(OFS_COUNT, 8'hFE);
    tk(1);
    rd(OFS_COUNT, 8'hFF);
    tk(1);
    rd(OFS_COUNT, 8'h00);
    rd(OFS_FLAGS, 8'h01);
    tk(1);
    rd(OFS_FLAGS, 8'h03);
    wr(OFS_FLAGS, 8'h03);
    rd(OFS_FLAGS, 8'h00);
    // preset the output state before the pin is enabled
    wr(OFS_CTRL, ctl(1'b1, OAS_SET, MODE_NORMAL));
    rd(OFS_CTRL, 8'h30);
    rd(OFS_PORT, 8'h04);
    rd(OFS_FLAGS, 8'h00);
    chk_pin(1'b0, 1'b0);
    wr(OFS_PORT, 8'h02);
    chk_pin(1'b1, 1'b1);
    wr(OFS_CTRL, ctl(1'b1, OAS_CLEAR, MODE_NORMAL));
    wr(OFS_PORT, 8'h03);
    chk_pin(1'b1, 1'b0);
    wr(OFS_CTRL, ctl(1'b0, OAS_NONE, MODE_NORMAL));
    chk_pin(1'b1, 1'b1);
    c = 8'h02 + 8'(lfsr[2:0]);
    lfsr = lfsr_next(lfsr);
    wr(OFS_COMPARE, c);
    wr(OFS_COUNT, 8'h00);
    wr(OFS_FLAGS, 8'h03);
    wr(OFS_CTRL, ctl(1'b0, OAS_TOGGLE, MODE_CLEAR));
    tk(int'(c));
    rd(OFS_COUNT, c);
    rd(OFS_FLAGS, 8'h00);
    tk(1);
    rd(OFS_COUNT, 8'h00);
    rd(OFS_FLAGS, 8'h02);
    rd(OFS_PORT, 8'h07);
    chk_pin(1'b1, 1'b1);
    tk(int'(c) + 1);
    rd(OFS_PORT, 8'h03);
    wr(OFS_FLAGS, 8'h03);
    wr(OFS_COUNT, c);
    tk(1);
    rd(OFS_COUNT, c + 8'h01);
    rd(OFS_FLAGS, 8'h00);
    // count is already past the compare value: the match is missed
    tk(254 - int'(c));
    rd(OFS_COUNT, 8'hFF);
    tk(1);
    rd(OFS_COUNT, 8'h00);
    rd(OFS_FLAGS, 8'h01);
    wr(OFS_CTRL, ctl(1'b0, OAS_NONE, MODE_CLEAR));
    tk(int'(c) + 1);
    rd(OFS_COUNT, 8'h00);
    rd(OFS_PORT, 8'h03);
    p = 8'h01 + 8'(lfsr[3:0]);
    lfsr = lfsr_next(lfsr);
    for (int k = 2; k < 4; k++) begin
      oc = (k == 2);
      wr(OFS_CTRL, ctl(1'b0, 2'(k), MODE_FAST));
      wr(OFS_COMPARE, p);
      wr(OFS_COUNT, 8'hFD);
      wr(OFS_FLAGS, 8'h03);
      tk(3);
      rd(OFS_COUNT, 8'h00);
      rd(OFS_FLAGS, 8'h01);
      rd(OFS_PORT, {5'h00, oc, 2'b11});
      tk(int'(p));
      rd(OFS_PORT, {5'h00, oc, 2'b11});
      tk(1);
      rd(OFS_PORT, {5'h00, ~oc, 2'b11});
      rd(OFS_COMPARE, p);
      chk_pin(1'b1, ~oc);
    end
    // compare at max: wrap outranks the match, level never drops
    wr(OFS_CTRL, ctl(1'b0, OAS_CLEAR, MODE_FAST));
    wr(OFS_COMPARE, 8'hFF);
    wr(OFS_COUNT, 8'hFF);
    tk(1);
    tk(256);
    rd(OFS_COUNT, 8'h00);
    rd(OFS_PORT, 8'h07);
    // compare at zero: one-tick pulse after the wrap
    wr(OFS_COMPARE, 8'h00);
    wr(OFS_COUNT, 8'hFF);
    tk(1);
    rd(OFS_PORT, 8'h07);
    tk(1);
    rd(OFS_PORT, 8'h03);
    wr(OFS_CTRL, ctl(1'b0, OAS_TOGGLE, MODE_FAST));
    tk(255);
    rd(OFS_PORT, 8'h03);
    tk(1);
    rd(OFS_PORT, 8'h07);
    // second reset with the output state set
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(OFS_PORT, 8'h00);
    chk_pin(1'b0, 1'b0);
    tally_and_finish();
  end
endmodule

// *** bench/tmw_pin_load.sv ***
/*
  Far-side model of the timer's port pin: an external load with a pull-down.
  Assumes pin_oe is high while the timer drives the pin.
*/
module tmw_pin_load (
  // timer side
  input wire logic pin_out,
  input wire logic pin_oe,
  // line as seen by the load
  output logic pin_level
);
  timeunit 1ns;
  timeprecision 1ps;
  // a released line falls to the pull-down, it never keeps the last value
  assign pin_level = pin_oe ? pin_out : 1'b0;
endmodule

// *** logic/tmw_axil_slave.sv ***
/*
  AXI4-Lite slave: turns bus transfers into one-cycle register strobes.
  Assumes the core answers reads combinationally from rd_addr.
*/
module tmw_axil_slave
  import tmw_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // write channels
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [DATA_W-1:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // read channels
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [DATA_W-1:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // core side
  tmw_reg_if.slv rif
);
  logic aw_held_reg, w_held_reg;
  logic [ADDR_W-1:0] awaddr_reg;
  logic [DATA_W-1:0] wdata_reg;
  logic [3:0] wstrb_reg;

  // address and data are taken independently, in either order
  assign awready = !aw_held_reg && !bvalid;
  assign wready = !w_held_reg && !bvalid;
  assign rif.wr_en = aw_held_reg && w_held_reg && !bvalid;
  assign rif.wr_addr = awaddr_reg;
  assign rif.wr_data = wdata_reg;
  assign rif.wr_strb = wstrb_reg;
  assign rif.rd_addr = araddr;
  assign arready = !rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      awaddr_reg <= '0;
      wdata_reg <= '0;
      wstrb_reg <= '0;
    end else if (rif.wr_en) begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
    end else begin
      if (awvalid && awready) begin
        aw_held_reg <= 1'b1;
        awaddr_reg <= awaddr;
      end
      if (wvalid && wready) begin
        w_held_reg <= 1'b1;
        wdata_reg <= wdata;
        wstrb_reg <= wstrb;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
    end else if (rif.wr_en) begin
      bvalid <= 1'b1;
      bresp <= tmw_addr_ok(awaddr_reg) ? RESP_OKAY : RESP_SLVERR;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata <= RD_ZERO;
      rresp <= RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rdata <= rif.rd_data;
      rresp <= tmw_addr_ok(araddr) ? RESP_OKAY : RESP_SLVERR;
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end
endmodule

// *** logic/tmw_pkg.sv ***
/*
  Shared constants for the 8-bit waveform timer: register map, field
  positions, reset values, mode and output-action encodings.
  Assumes a 32-bit AXI4-Lite register bus with byte addresses.
*/
package tmw_pkg;
  // ------------------------------------------------------------
  // bus
  // ------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [31:0] RD_ZERO = 32'h0000_0000;
  // ------------------------------------------------------------
  // register map
  // ------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_COUNT = 8'h04;
  localparam logic [7:0] OFS_COMPARE = 8'h08;
  localparam logic [7:0] OFS_FLAGS = 8'h0C;
  localparam logic [7:0] OFS_PORT = 8'h10;
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_OAS_LSB = 4;
  localparam int CTRL_FORCE_BIT = 7;
  localparam int FLAG_OVF_BIT = 0;
  localparam int FLAG_CMP_BIT = 1;
  localparam int PORT_OUT_BIT = 0;
  localparam int PORT_DIR_BIT = 1;
  localparam int PORT_OC_BIT = 2;
  // ------------------------------------------------------------
  // values
  // ------------------------------------------------------------
  localparam logic [7:0] CNT_BOTTOM = 8'h00;
  localparam logic [7:0] CNT_MAX = 8'hFF;
  localparam logic [7:0] CNT_STEP = 8'h01;
  localparam logic [7:0] RST_COMPARE = 8'h00;
  localparam logic [1:0] OAS_NONE = 2'h0;
  localparam logic [1:0] OAS_TOGGLE = 2'h1;
  localparam logic [1:0] OAS_CLEAR = 2'h2;
  localparam logic [1:0] OAS_SET = 2'h3;
  typedef enum logic [1:0] {MODE_NORMAL, MODE_PHASE, MODE_CLEAR, MODE_FAST} tmw_mode_e;

  function automatic logic tmw_addr_ok(input logic [7:0] a);
    return a inside {OFS_CTRL, OFS_COUNT, OFS_COMPARE, OFS_FLAGS, OFS_PORT};
  endfunction
endpackage

// *** logic/tmw_reg_if.sv ***
/*
  Register access strobes between the bus slave and the timer core.
  Assumes both ends run on the same clock.
*/
interface tmw_reg_if;
  logic wr_en;
  logic [7:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic [7:0] rd_addr;
  logic [31:0] rd_data;
  modport slv (output wr_en, output wr_addr, output wr_data, output wr_strb,
               output rd_addr, input rd_data);
  modport core (input wr_en, input wr_addr, input wr_data, input wr_strb,
                input rd_addr, output rd_data);
endinterface

// *** logic/tmw_timer.sv ***
/*
  8-bit timer/counter with one compare channel, waveform output and
  port-pin override, registers reached over AXI4-Lite.
  Assumes timer_tick is a one-cycle enable from a prescaler on aclk.
*/
// Operation
// - reset clears the compare output state and the pin
// - nonzero output action select routes compare state to pin; direction unchanged
// - output action select zero leaves compare state alone on match
// - new action applies at next match; force strobe applies it now, outside PWM modes only
// - mode selects counting; action select only shapes output
// - normal mode counts up, wraps 0xFF to 0x00, counter writable anytime
// - normal mode sets overflow flag as counter becomes zero
// - clear-on-match mode clears counter when it equals compare value
// - clear-on-match mode sets compare flag each period top
// - clear-on-match compare writes unbuffered; missed match wraps through 0xFF
// - clear-on-match with action one toggles output on every match
// - clear-on-match sets overflow flag on MAX to 0x00 pass
// - fast PWM counts 0 to 0xFF then clears, single slope
// - fast PWM action 2 clears on match sets at wrap; 3 inverse
// - fast PWM sets overflow flag at maximum count
// - fast PWM period is 256 ticks
// - compare zero gives one-tick pulse; compare max gives constant level
// - fast PWM action one toggles on match, buffering still active
// - PWM compare writes buffered until update point; otherwise direct
// - equality sets compare flag next tick; cleared by writing one
// - counter write blocks compare match in the next tick
// - force strobe changes output only, no flag, no counter clear
module tmw_timer
  import tmw_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // timer tick enable from prescaler
  input wire logic timer_tick,
  // axi4-lite write
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [DATA_W-1:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // axi4-lite read
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [DATA_W-1:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // port pin
  output logic pin_out,
  output logic pin_oe
);
  // ------------------------------------------------------------
  // bus slave
  // ------------------------------------------------------------
  tmw_reg_if rif ();

  tmw_axil_slave u_bus (
    .aclk(aclk),
    .aresetn(aresetn),
    .awaddr(awaddr),
    .awvalid(awvalid),
    .awready(awready),
    .wdata(wdata),
    .wstrb(wstrb),
    .wvalid(wvalid),
    .wready(wready),
    .bresp(bresp),
    .bvalid(bvalid),
    .bready(bready),
    .araddr(araddr),
    .arvalid(arvalid),
    .arready(arready),
    .rdata(rdata),
    .rresp(rresp),
    .rvalid(rvalid),
    .rready(rready),
    .rif(rif)
  );

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  tmw_mode_e mode_reg;
  logic [1:0] oas_reg;
  logic [7:0] cnt_reg;
  logic [7:0] cmp_act_reg;
  logic [7:0] cmp_buf_reg;
  logic ovf_reg, cmpf_reg, oc_reg, block_reg;
  logic port_out_reg, port_dir_reg;

  function automatic logic wr_hit(input logic [7:0] ofs);
    return rif.wr_en && rif.wr_strb[0] && (rif.wr_addr == ofs);
  endfunction

  // action on a match, shared by real and forced matches
  function automatic logic oc_act(input logic [1:0] oas, input logic cur);
    logic r;
    r = cur;
    unique case (oas)
      OAS_NONE: r = cur;
      OAS_TOGGLE: r = ~cur;
      OAS_CLEAR: r = 1'b0;
      OAS_SET: r = 1'b1;
    endcase
    return r;
  endfunction

  function automatic logic mode_is_pwm(input tmw_mode_e m);
    return (m == MODE_FAST) || (m == MODE_PHASE);
  endfunction

  logic ctrl_wr, cnt_wr, cmp_wr, flag_wr, port_wr;
  logic force_now, match_w, wrap_w, ovf_set, cmpf_set, ovr_src;
  tmw_mode_e wmode;
  logic [1:0] woas;

  assign ctrl_wr = wr_hit(OFS_CTRL);
  assign cnt_wr = wr_hit(OFS_COUNT);
  assign cmp_wr = wr_hit(OFS_COMPARE);
  assign flag_wr = wr_hit(OFS_FLAGS);
  assign port_wr = wr_hit(OFS_PORT);
  assign wmode = tmw_mode_e'(rif.wr_data[CTRL_MODE_LSB +: 2]);
  assign woas = rif.wr_data[CTRL_OAS_LSB +: 2];
  // strobe acts with the mode and action written alongside it
  assign force_now = ctrl_wr && rif.wr_data[CTRL_FORCE_BIT] && !mode_is_pwm(wmode);
  // phase-correct mode is not implemented: no matches, counter holds
  assign match_w = (cnt_reg == cmp_act_reg) && !block_reg && (mode_reg != MODE_PHASE);
  assign wrap_w = (cnt_reg == CNT_MAX);
  assign ovf_set = timer_tick && wrap_w && (mode_reg != MODE_PHASE) && !cnt_wr;
  assign cmpf_set = timer_tick && match_w;

  // ------------------------------------------------------------
  // control
  // ------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_reg <= MODE_NORMAL;
      oas_reg <= OAS_NONE;
    end else if (ctrl_wr) begin
      mode_reg <= wmode;
      oas_reg <= woas;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      port_out_reg <= 1'b0;
      port_dir_reg <= 1'b0;
    end else if (port_wr) begin
      port_out_reg <= rif.wr_data[PORT_OUT_BIT];
      port_dir_reg <= rif.wr_data[PORT_DIR_BIT];
    end
  end

  // ------------------------------------------------------------
  // counter
  // ------------------------------------------------------------
  // processor write beats any tick-driven clear or count
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_reg <= CNT_BOTTOM;
    end else if (cnt_wr) begin
      cnt_reg <= rif.wr_data[7:0];
    end else if (timer_tick) begin
      unique case (mode_reg)
        MODE_NORMAL: cnt_reg <= cnt_reg + CNT_STEP;
        MODE_FAST: cnt_reg <= cnt_reg + CNT_STEP;
        MODE_CLEAR: cnt_reg <= match_w ? CNT_BOTTOM : cnt_reg + CNT_STEP;
        MODE_PHASE: cnt_reg <= cnt_reg;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      block_reg <= 1'b0;
    end else if (cnt_wr) begin
      block_reg <= 1'b1;
    end else if (timer_tick) begin
      block_reg <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // compare value
  // ------------------------------------------------------------
  // buffered in PWM so a period never sees a half-updated threshold
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cmp_buf_reg <= RST_COMPARE;
      cmp_act_reg <= RST_COMPARE;
    end else if (cmp_wr) begin
      cmp_buf_reg <= rif.wr_data[7:0];
      if (!mode_is_pwm(mode_reg)) begin
        cmp_act_reg <= rif.wr_data[7:0];
      end
    end else if (timer_tick && (mode_reg == MODE_FAST) && wrap_w) begin
      cmp_act_reg <= cmp_buf_reg;
    end
  end

  // ------------------------------------------------------------
  // flags: hardware set wins over a write-one clear
  // ------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ovf_reg <= 1'b0;
    end else if (ovf_set) begin
      ovf_reg <= 1'b1;
    end else if (flag_wr && rif.wr_data[FLAG_OVF_BIT]) begin
      ovf_reg <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cmpf_reg <= 1'b0;
    end else if (cmpf_set) begin
      cmpf_reg <= 1'b1;
    end else if (flag_wr && rif.wr_data[FLAG_CMP_BIT]) begin
      cmpf_reg <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // compare output state
  // ------------------------------------------------------------
  // a force in the same cycle as a tick wins; the tick action is dropped
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      oc_reg <= 1'b0;
    end else if (force_now) begin
      oc_reg <= oc_act(woas, oc_reg);
    end else if (timer_tick) begin
      unique case (mode_reg)
        MODE_NORMAL, MODE_CLEAR: begin
          if (match_w) begin
            oc_reg <= oc_act(oas_reg, oc_reg);
          end
        end
        MODE_FAST: begin
          // wrap outranks a match at MAX, giving a constant level
          if (wrap_w && oas_reg[1]) begin
            oc_reg <= ~oas_reg[0];
          end else if (match_w) begin
            oc_reg <= oc_act(oas_reg, oc_reg);
          end
        end
        MODE_PHASE: oc_reg <= oc_reg;
      endcase
    end
  end

  // ------------------------------------------------------------
  // pin override
  // ------------------------------------------------------------
  assign ovr_src = (oas_reg != OAS_NONE) ? oc_reg : port_out_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_out <= 1'b0;
      pin_oe <= 1'b0;
    end else begin
      pin_out <= ovr_src;
      pin_oe <= port_dir_reg;
    end
  end

  // ------------------------------------------------------------
  // read mux
  // ------------------------------------------------------------
  always_comb begin
    rif.rd_data = RD_ZERO;
    case (rif.rd_addr)
      OFS_CTRL: begin
        rif.rd_data[CTRL_MODE_LSB +: 2] = mode_reg;
        rif.rd_data[CTRL_OAS_LSB +: 2] = oas_reg;
      end
      OFS_COUNT: rif.rd_data[7:0] = cnt_reg;
      OFS_COMPARE: rif.rd_data[7:0] = cmp_buf_reg;
      OFS_FLAGS: begin
        rif.rd_data[FLAG_OVF_BIT] = ovf_reg;
        rif.rd_data[FLAG_CMP_BIT] = cmpf_reg;
      end
      OFS_PORT: begin
        rif.rd_data[PORT_OUT_BIT] = port_out_reg;
        rif.rd_data[PORT_DIR_BIT] = port_dir_reg;
        rif.rd_data[PORT_OC_BIT] = oc_reg;
      end
      default: rif.rd_data = RD_ZERO;
    endcase
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_cnt_written;
    cnt_wr;
  endsequence

  sequence s_first_tick;
    block_reg && timer_tick && !cnt_wr && !flag_wr;
  endsequence

  AST_RESET_OC: assert property ($rose(aresetn) |-> !oc_reg)
    else $error("compare output state not cleared by reset");

  AST_PIN_OVR: assert property (##1 pin_out == $past(ovr_src))
    else $error("pin does not follow override source");

  AST_OAS_ZERO: assert property (timer_tick && oas_reg == OAS_NONE && !force_now |=> $stable(oc_reg))
    else $error("output changed with action select zero");

  AST_NORMAL_INC: assert property (timer_tick && mode_reg == MODE_NORMAL && !cnt_wr
    |=> cnt_reg == 8'($past(cnt_reg) + CNT_STEP))
    else $error("normal mode did not increment");

  AST_OVF_SET: assert property (timer_tick && wrap_w && !cnt_wr && mode_reg != MODE_PHASE
    |=> ovf_reg && cnt_reg == CNT_BOTTOM)
    else $error("overflow flag not set at wrap");

  AST_CTC_CLEAR: assert property (timer_tick && mode_reg == MODE_CLEAR && match_w && !cnt_wr
    |=> cnt_reg == CNT_BOTTOM && cmpf_reg)
    else $error("clear-on-match did not clear counter");

  AST_CTC_TOGGLE: assert property (timer_tick && mode_reg == MODE_CLEAR && oas_reg == OAS_TOGGLE
    && match_w && !force_now |=> oc_reg != $past(oc_reg))
    else $error("toggle missed on match");

  AST_PWM_WRAP: assert property (timer_tick && mode_reg == MODE_FAST && wrap_w && oas_reg == OAS_CLEAR
    && !force_now |=> oc_reg)
    else $error("fast pwm output not set at wrap");

  AST_PWM_RELOAD: assert property (timer_tick && mode_reg == MODE_FAST && wrap_w && !cmp_wr
    |=> cmp_act_reg == $past(cmp_buf_reg))
    else $error("compare buffer not copied at wrap");

  AST_BLOCK: assert property (s_first_tick |=> $stable(cmpf_reg))
    else $error("match not blocked after counter write");

  AST_BLOCK_ARM: assert property (s_cnt_written |=> block_reg)
    else $error("counter write did not arm match blocking");

  AST_FORCE_NOFLAG: assert property (force_now && !timer_tick && !cmpf_reg |=> !cmpf_reg)
    else $error("force strobe set compare flag");

  AST_TICK_ONLY: assert property (!timer_tick && !cnt_wr |=> $stable(cnt_reg))
    else $error("counter moved without tick");
endmodule
